// [tb/btp_mem_model.sv]
`timescale 1ns/1ps

module btp_mem_model (
	// clock
	input  wire logic        clk,
	// control memory
	input  wire logic [15:0] fetch_pointer,
	input  wire logic        bad_cm,
	output logic      [23:0] cm_word,
	// data memory
	input  wire logic        dm_wr,
	input  wire logic [8:0]  dm_wdata_par,
	input  wire logic        dm_rd_valid,
	input  wire logic        bad_dm,
	output logic      [8:0]  dm_rdata
);
	logic        wr_q;
	logic [8:0]  mem_q;
	logic [22:0] body;

	// model generates odd parity over the word itself; bad_cm corrupts only bit 23
	assign body    = {fetch_pointer[6:0], fetch_pointer};
	assign cm_word = {~^body ^ bad_cm, body};
	// idle bus shows inverted data so stale values never pass
	assign dm_rdata = dm_rd_valid ? mem_q ^ {bad_dm, 8'h00} : ~mem_q;

	always_ff @(posedge clk)
	begin
		wr_q <= dm_wr;
		if (wr_q)
			mem_q <= dm_wdata_par;
	end
endmodule : btp_mem_model

// [tb/btp_trap_sva.sv]
`timescale 1ns/1ps

module btp_trap_sva (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// sequencer and memory inputs
	input wire logic        reset_key,
	input wire logic        fetch_valid,
	input wire logic [15:0] fetch_pointer,
	input wire logic [23:0] cm_word,
	input wire logic        dm_wr,
	input wire logic [7:0]  dm_wdata,
	input wire logic        dm_rd_valid,
	input wire logic [8:0]  dm_rdata,
	// trap outputs
	input wire logic        pc_load,
	input wire logic [15:0] pc_vector,
	input wire logic        fetch_discard,
	input wire logic        stack_push,
	input wire logic [15:0] stack_data,
	input wire logic [23:0] instr_out,
	input wire logic [8:0]  dm_wdata_par
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence cm_bad_s;
		fetch_valid && !(^cm_word);
	endsequence
	sequence vec_s(logic [15:0] v);
		pc_load && pc_vector == v;
	endsequence

	pwr_vec_a: assert property ($rose(rst_n) |-> ##[1:2] vec_s(16'h8003))
		else $error("power-on vector wrong");
	key_vec_a: assert property ($rose(reset_key) |-> ##[1:5] vec_s(16'h8001))
		else $error("reset key vector wrong");
	cm_trap_a: assert property (cm_bad_s |-> fetch_discard ##1 vec_s(16'h8000))
		else $error("control parity trap wrong");
	stack_push_a: assert property (cm_bad_s |=> stack_push
		&& stack_data == $past(fetch_pointer) + 16'h0001)
		else $error("return address wrong");
	dm_trap_a: assert property (dm_rd_valid && !(^dm_rdata) |=> vec_s(16'h8002))
		else $error("data parity trap wrong");
	wr_par_a: assert property (dm_wr |=> dm_wdata_par
		== {~^$past(dm_wdata), $past(dm_wdata)})
		else $error("write parity wrong");
	squash_a: assert property (fetch_discard |-> instr_out == 24'h000000)
		else $error("discarded fetch leaked");
	good_pass_a: assert property (fetch_valid && ^cm_word |-> !fetch_discard
		&& instr_out == cm_word)
		else $error("good fetch not passed");
endmodule : btp_trap_sva

bind btp_trap_unit btp_trap_sva i_btp_trap_sva (.clk, .rst_n, .reset_key, .fetch_valid,
	.fetch_pointer, .cm_word, .dm_wr, .dm_wdata, .dm_rd_valid, .dm_rdata, .pc_load,
	.pc_vector, .fetch_discard, .stack_push, .stack_data, .instr_out, .dm_wdata_par);

// [tb/tb.sv]
`timescale 1ns/1ps

module tb;
	logic clk, rst_n, reset_key, fetch_valid, dm_wr, dm_rd_valid, step_done;
	logic bad_cm, bad_dm, pc_load, fetch_discard, stack_push, init_passed;
	logic [15:0] fp, pc_vector, stack_data;
	logic [23:0] cm_word, instr_out;
	logic [7:0]  wd;
	logic [8:0]  dm_rdata, dm_wdata_par;
	btp_pkg::btp_trap_t trap_cause;
	btp_pkg::btp_init_t init_state;
	btp_pkg::btp_load_t load_state;
	int          num_errors, n_checks;
	logic        rom_we;
	logic [9:0]  rom_idx;
	logic [23:0] rom_wd;

	btp_trap_unit i_btp_trap_unit (.clk, .rst_n, .reset_key, .fetch_valid,
		.fetch_pointer(fp), .cm_word, .dm_wr, .dm_wdata(wd), .dm_rd_valid, .dm_rdata,
		.rom_init_we(rom_we), .rom_init_idx(rom_idx), .rom_init_word(rom_wd),
		.step_done, .step_fail(1'b0), .pc_load, .pc_vector, .fetch_discard,
		.stack_push, .stack_data, .instr_out, .dm_wdata_par, .trap_cause,
		.init_state, .load_state, .init_passed);
	btp_mem_model i_btp_mem_model (.clk, .fetch_pointer(fp), .bad_cm, .cm_word,
		.dm_wr, .dm_wdata_par, .dm_rd_valid, .bad_dm, .dm_rdata);

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
		n_checks++;
		if (s !== e)
		begin
			$display("ERROR %s exp %h got %h", n, e, s);
			num_errors++;
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// poll a bounded number of cycles for the vector load
	task automatic wvec(input logic [15:0] v);
		for (int i = 0; i < 8; i++)
		begin
			tick(1);
			if (pc_load === 1'b1)
				break;
		end
		chk("pc_load", 1'b1, pc_load);
		chk("pc_vector", v, pc_vector);
	endtask : wvec

	task automatic step(input string n, input logic [23:0] e, input bit ld);
		@(posedge clk);
		step_done <= 1'b1;
		@(posedge clk);
		step_done <= 1'b0;
		tick(2);
		chk(n, e, ld ? 24'(load_state) : 24'(init_state));
	endtask : step

	task automatic t_fetch(input logic [15:0] p, input logic b);
		logic [22:0] y;
		y = {p[6:0], p};
		@(posedge clk);
		fetch_valid <= 1'b1;
		fp <= p;
		bad_cm <= b;
		#1;
		chk("fetch_discard", b, fetch_discard);
		chk("instr_out", b ? 24'h000000 : {~^y, y}, instr_out);
		@(posedge clk);
		fetch_valid <= 1'b0;
		bad_cm <= 1'b0;
		#1;
		chk("pc_load", b, pc_load);
		if (b)
		begin
			chk("pc_vector", 16'h8000, pc_vector);
			chk("stack_data", 16'(p + 16'h0001), stack_data);
			chk("trap_cause", btp_pkg::BTP_TRAP_CM_PAR, trap_cause);
		end
	endtask : t_fetch

	task automatic t_dm(input logic [7:0] v, input logic b);
		@(posedge clk);
		dm_wr <= 1'b1;
		wd <= v;
		@(posedge clk);
		dm_wr <= 1'b0;
		#1;
		chk("dm_wdata_par", {~^v, v}, dm_wdata_par);
		@(posedge clk);
		dm_rd_valid <= 1'b1;
		bad_dm <= b;
		@(posedge clk);
		dm_rd_valid <= 1'b0;
		bad_dm <= 1'b0;
		#1;
		chk("pc_load", b, pc_load);
		if (b)
		begin
			chk("pc_vector", 16'h8002, pc_vector);
			chk("trap_cause", btp_pkg::BTP_TRAP_DM_PAR, trap_cause);
		end
	endtask : t_dm

	task automatic t_key(input logic [23:0] e);
		@(posedge clk);
		reset_key <= 1'b1;
		wvec(16'h8001);
		chk("trap_cause", btp_pkg::BTP_TRAP_RESET, trap_cause);
		@(posedge clk);
		reset_key <= 1'b0;
		tick(3);
		chk("load_state", e, load_state);
	endtask : t_key

	task automatic t_load(input int n);
		btp_pkg::btp_load_t ord[5] = '{btp_pkg::BTP_LD_FIND, btp_pkg::BTP_LD_LOAD,
			btp_pkg::BTP_LD_VERIFY, btp_pkg::BTP_LD_DPAR, btp_pkg::BTP_LD_XFER};
		for (int i = 0; i < n; i++)
			step("load_state", ord[i], 1);
	endtask : t_load

	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize

	initial
	begin
		{rst_n, reset_key, fetch_valid, dm_wr, dm_rd_valid, step_done, bad_cm, bad_dm} = 8'h00;
		fp = 16'h0000;
		wd = 8'h00;
		num_errors = 0;
		n_checks = 0;
		// bootstrap word at 800F holds the same bad-parity word the model shows
		rom_we = 1'b0;
		rom_idx = 10'h00F;
		rom_wd = {^{7'h0F, 16'h800F}, 7'h0F, 16'h800F};
		@(posedge clk);
		rom_we <= 1'b1;
		@(posedge clk);
		rom_we <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		wvec(16'h8003);
		chk("trap_cause", btp_pkg::BTP_TRAP_POWER, trap_cause);
		step("init_state", btp_pkg::BTP_MI_PTEST, 0);
		t_fetch(16'h800F, 1'b1);
		tick(2);
		chk("init_state", btp_pkg::BTP_MI_EXER, init_state);
		step("init_state", btp_pkg::BTP_MI_VERIFY, 0);
		step("init_state", btp_pkg::BTP_MI_ZERO, 0);
		step("init_state", btp_pkg::BTP_MI_LOOP, 0);
		chk("init_passed", 1'b1, init_passed);
		t_fetch(16'h1234, 1'b0);
		t_fetch(16'hFFFF, 1'b1);
		t_dm(8'h00, 1'b0);
		t_dm(8'h01, 1'b0);
		t_dm(8'hA7, 1'b1);
		t_key(btp_pkg::BTP_LD_READY);
		t_load(2);
		t_key(btp_pkg::BTP_LD_ABORT);
		t_key(btp_pkg::BTP_LD_READY);
		t_load(5);
		summarize;
	end

	initial
	begin
		#100000;
		num_errors++;
		summarize;
	end
endmodule : tb

// [verilog/btp_boot_rom.sv]
`timescale 1ns/1ps
`include "btp_defines.svh"

// bootstrap store: three byte-wide lanes combined into one microword
module btp_boot_rom (
	// clock
	input  wire logic                          clk,
	// read port and init port
	input  wire logic [`BTP_ROM_IDX_W-1:0]     rd_idx,
	input  wire logic [`BTP_ROM_LANES*8-1:0]   init_word,
	input  wire logic                          init_we,
	input  wire logic [`BTP_ROM_IDX_W-1:0]     init_idx,
	output logic      [`BTP_ROM_LANES*8-1:0]   rd_word
);
	genvar g;
	generate
		for (g = 0; g < `BTP_ROM_LANES; g = g + 1)
		begin : g_lane
			logic [7:0] mem [0:`BTP_ROM_DEPTH-1];
			// contents are programmed once through the init port, standing in for the parts
			always_ff @(posedge clk)
			begin
				if (init_we)
					mem[init_idx] <= init_word[g*8 +: 8];
			end
			assign rd_word[g*8 +: 8] = mem[rd_idx];
		end
	endgenerate
endmodule : btp_boot_rom

// [verilog/btp_defines.svh]
`ifndef BTP_DEFINES_SVH
`define BTP_DEFINES_SVH

// control-store geometry
`define BTP_CM_ADDR_W      16
`define BTP_CM_WORD_W      24
`define BTP_CM_PAR_BIT     23
`define BTP_DM_BYTE_W      8
// trap vectors inside the bootstrap store
`define BTP_VEC_CM_PARITY  16'h8000
`define BTP_VEC_RESET_KEY  16'h8001
`define BTP_VEC_DM_PARITY  16'h8002
`define BTP_VEC_POWER_ON   16'h8003
`define BTP_VEC_PARITY_TST 16'h800F
// bootstrap store: three 1024 x 8 parts
`define BTP_ROM_BASE       16'h8000
`define BTP_ROM_DEPTH      1024
`define BTP_ROM_IDX_W      10
`define BTP_ROM_LANES      3
// file-load hand-off address
`define BTP_LOAD_ENTRY     16'h3000

`endif

// [verilog/btp_pkg.sv]
package btp_pkg;
	typedef enum logic [2:0] {
		BTP_TRAP_NONE    = 3'h0,
		BTP_TRAP_POWER   = 3'h1,
		BTP_TRAP_RESET   = 3'h2,
		BTP_TRAP_CM_PAR  = 3'h3,
		BTP_TRAP_DM_PAR  = 3'h4
	} btp_trap_t;

	typedef enum logic [8:0] {
		BTP_LD_IDLE   = 9'b000000001,
		BTP_LD_READY  = 9'b000000010,
		BTP_LD_FIND   = 9'b000000100,
		BTP_LD_LOAD   = 9'b000001000,
		BTP_LD_VERIFY = 9'b000010000,
		BTP_LD_DPAR   = 9'b000100000,
		BTP_LD_XFER   = 9'b001000000,
		BTP_LD_ABORT  = 9'b010000000,
		BTP_LD_FAIL   = 9'b100000000
	} btp_load_t;

	typedef enum logic [5:0] {
		BTP_MI_POWER  = 6'b000001,
		BTP_MI_PTEST  = 6'b000010,
		BTP_MI_EXER   = 6'b000100,
		BTP_MI_VERIFY = 6'b001000,
		BTP_MI_ZERO   = 6'b010000,
		BTP_MI_LOOP   = 6'b100000
	} btp_init_t;
endpackage : btp_pkg

// [verilog/btp_trap_unit.sv]
`timescale 1ns/1ps
`include "btp_defines.svh"

module btp_trap_unit (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	// operator key (asynchronous pin)
	input  wire logic                        reset_key,
	// instruction fetch from control memory
	input  wire logic                        fetch_valid,
	input  wire logic [`BTP_CM_ADDR_W-1:0]   fetch_pointer,
	input  wire logic [`BTP_CM_WORD_W-1:0]   cm_word,
	// data memory
	input  wire logic                        dm_wr,
	input  wire logic [`BTP_DM_BYTE_W-1:0]   dm_wdata,
	input  wire logic                        dm_rd_valid,
	input  wire logic [`BTP_DM_BYTE_W:0]     dm_rdata,
	// bootstrap store programming
	input  wire logic                        rom_init_we,
	input  wire logic [`BTP_ROM_IDX_W-1:0]   rom_init_idx,
	input  wire logic [`BTP_CM_WORD_W-1:0]   rom_init_word,
	// sequencer step reports
	input  wire logic                        step_done,
	input  wire logic                        step_fail,
	// sequencer control
	output logic                             pc_load,
	output logic      [`BTP_CM_ADDR_W-1:0]   pc_vector,
	output logic                             fetch_discard,
	output logic                             stack_push,
	output logic      [`BTP_CM_ADDR_W-1:0]   stack_data,
	output logic      [`BTP_CM_WORD_W-1:0]   instr_out,
	// data memory write with parity
	output logic      [`BTP_DM_BYTE_W:0]     dm_wdata_par,
	// status
	output btp_pkg::btp_trap_t               trap_cause,
	output btp_pkg::btp_init_t               init_state,
	output btp_pkg::btp_load_t               load_state,
	output logic                             init_passed
);
	// odd parity: stored bit makes total ones count odd
	function automatic logic odd_ok(input logic [`BTP_CM_WORD_W-1:0] w);
		odd_ok = ^w;
	endfunction : odd_ok

	logic        key_s1_q;
	logic        key_s2_q;
	logic        key_s3_q;
	logic        por_q;
	logic        trap_q;
	logic        push_q;
	logic [`BTP_CM_ADDR_W-1:0] vec_q;
	logic [`BTP_CM_ADDR_W-1:0] ret_q;
	logic [`BTP_DM_BYTE_W:0]   dwp_q;
	btp_pkg::btp_trap_t cause_q;
	btp_pkg::btp_init_t mi_q;
	btp_pkg::btp_init_t mi_d;
	btp_pkg::btp_load_t ld_q;
	btp_pkg::btp_load_t ld_d;
	logic        passed_q;

	// key pin crosses into clk domain through two flops
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			key_s1_q <= 1'b0;
			key_s2_q <= 1'b0;
			key_s3_q <= 1'b0;
		end
		else
		begin
			key_s1_q <= reset_key;
			key_s2_q <= key_s1_q;
			key_s3_q <= key_s2_q;
		end
	end
	wire key_press = key_s2_q & ~key_s3_q;

	// bootstrap store read when fetch is inside its window
	wire [`BTP_CM_ADDR_W-1:0] rom_off = fetch_pointer - `BTP_ROM_BASE;
	wire in_rom = (fetch_pointer >= `BTP_ROM_BASE)
	              && (rom_off < `BTP_CM_ADDR_W'(`BTP_ROM_DEPTH));
	wire [`BTP_CM_WORD_W-1:0] rom_word;

	btp_boot_rom u_rom (
		.clk       (clk),
		.rd_idx    (rom_off[`BTP_ROM_IDX_W-1:0]),
		.init_word (rom_init_word),
		.init_we   (rom_init_we),
		.init_idx  (rom_init_idx),
		.rd_word   (rom_word)
	);

	wire [`BTP_CM_WORD_W-1:0] fetched = in_rom ? rom_word : cm_word;
	// parity is checked, never generated, on control words
	wire cm_bad = fetch_valid & ~odd_ok(fetched);
	wire dm_bad = dm_rd_valid & ~(^dm_rdata);
	wire par_bit = fetched[`BTP_CM_PAR_BIT];

	// priority: power-on, reset key, control parity, data parity
	wire trap_req = por_q | key_press | cm_bad | dm_bad;
	wire [`BTP_CM_ADDR_W-1:0] vec_sel =
		por_q     ? `BTP_VEC_POWER_ON :
		key_press ? `BTP_VEC_RESET_KEY :
		cm_bad    ? `BTP_VEC_CM_PARITY :
		            `BTP_VEC_DM_PARITY;
	wire btp_pkg::btp_trap_t cause_sel =
		por_q     ? btp_pkg::BTP_TRAP_POWER :
		key_press ? btp_pkg::BTP_TRAP_RESET :
		cm_bad    ? btp_pkg::BTP_TRAP_CM_PAR :
		dm_bad    ? btp_pkg::BTP_TRAP_DM_PAR : btp_pkg::BTP_TRAP_NONE;
	// only parity traps save a return point
	wire push_sel = ~por_q & ~key_press & (cm_bad | dm_bad);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			por_q   <= 1'b1;
			trap_q  <= 1'b0;
			push_q  <= 1'b0;
			vec_q   <= '0;
			ret_q   <= '0;
			cause_q <= btp_pkg::BTP_TRAP_NONE;
		end
		else
		begin
			por_q  <= 1'b0;
			trap_q <= trap_req;
			push_q <= push_sel;
			if (trap_req)
			begin
				vec_q   <= vec_sel;
				cause_q <= cause_sel;
				ret_q   <= fetch_pointer + `BTP_CM_ADDR_W'(1);
			end
		end
	end

	// faulting word is squashed in the fetch cycle itself
	assign fetch_discard = cm_bad | trap_req;
	assign pc_load       = trap_q;
	assign pc_vector     = vec_q;
	assign stack_push    = push_q;
	assign stack_data    = ret_q;
	assign instr_out     = fetch_discard ? '0 : fetched;

	// data writes: hardware appends parity to each byte
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			dwp_q <= '0;
		else if (dm_wr)
			dwp_q <= {~(^dm_wdata), dm_wdata};
	end
	assign dm_wdata_par = dwp_q;

	// master initialization tracker; step_done advances, cm parity trap
	// is the expected outcome of the 800F test
	always_comb
	begin
		mi_d = mi_q;
		case (mi_q)
			btp_pkg::BTP_MI_POWER:  if (step_done) mi_d = btp_pkg::BTP_MI_PTEST;
			btp_pkg::BTP_MI_PTEST:
				if (cm_bad && fetch_pointer == `BTP_VEC_PARITY_TST)
					mi_d = btp_pkg::BTP_MI_EXER;
			btp_pkg::BTP_MI_EXER:   if (step_done) mi_d = btp_pkg::BTP_MI_VERIFY;
			btp_pkg::BTP_MI_VERIFY: if (step_done) mi_d = btp_pkg::BTP_MI_ZERO;
			btp_pkg::BTP_MI_ZERO:   if (step_done) mi_d = btp_pkg::BTP_MI_LOOP;
			btp_pkg::BTP_MI_LOOP:   mi_d = btp_pkg::BTP_MI_LOOP;
			default:                mi_d = btp_pkg::BTP_MI_POWER;
		endcase
	end

	// file load order; reset key aborts mid-load
	always_comb
	begin
		ld_d = ld_q;
		case (ld_q)
			btp_pkg::BTP_LD_IDLE:
				if (key_press && passed_q) ld_d = btp_pkg::BTP_LD_READY;
			btp_pkg::BTP_LD_ABORT, btp_pkg::BTP_LD_FAIL, btp_pkg::BTP_LD_XFER:
				if (key_press) ld_d = btp_pkg::BTP_LD_READY;
			default:
			begin
				if (key_press)
					ld_d = btp_pkg::BTP_LD_ABORT;
				else if (step_fail)
					ld_d = btp_pkg::BTP_LD_FAIL;
				else if (step_done)
				begin
					case (ld_q)
						btp_pkg::BTP_LD_READY:  ld_d = btp_pkg::BTP_LD_FIND;
						btp_pkg::BTP_LD_FIND:   ld_d = btp_pkg::BTP_LD_LOAD;
						btp_pkg::BTP_LD_LOAD:   ld_d = btp_pkg::BTP_LD_VERIFY;
						btp_pkg::BTP_LD_VERIFY: ld_d = btp_pkg::BTP_LD_DPAR;
						btp_pkg::BTP_LD_DPAR:   ld_d = btp_pkg::BTP_LD_XFER;
						default:                ld_d = btp_pkg::BTP_LD_FAIL;
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mi_q     <= btp_pkg::BTP_MI_POWER;
			ld_q     <= btp_pkg::BTP_LD_IDLE;
			passed_q <= 1'b0;
		end
		else
		begin
			// init steps only advance while the load tracker is still in BTP_LD_IDLE
			mi_q     <= (ld_q == btp_pkg::BTP_LD_IDLE) ? mi_d : mi_q;
			ld_q     <= ld_d;
			passed_q <= passed_q | (mi_q == btp_pkg::BTP_MI_LOOP);
		end
	end

	assign trap_cause  = cause_q;
	assign init_state  = mi_q;
	assign load_state  = ld_q;
	assign init_passed = passed_q;

	wire unused_ok = par_bit ^ (^dm_rdata[`BTP_DM_BYTE_W]);
endmodule : btp_trap_unit
